// ### srq_pkg.sv
package srq_pkg;

    // Instruction classes seen at decode
    typedef enum logic [4:0] {
        SRQ_OP_PLAIN,
        SRQ_OP_IDENTIFY_QUERY,
        SRQ_OP_INTERRUPT_RETURN,
        SRQ_OP_RESUME_SYS_MGMT,
        SRQ_OP_FULL_MEMORY_FENCE,
        SRQ_OP_LOAD_FENCE,
        SRQ_OP_CONTROL_REG_MOVE,
        SRQ_OP_DEBUG_REG_MOVE,
        SRQ_OP_GDT_LOAD,
        SRQ_OP_IDT_LOAD,
        SRQ_OP_LDT_LOAD,
        SRQ_OP_TASK_REG_LOAD,
        SRQ_OP_MODEL_REG_WRITE,
        SRQ_OP_CACHE_WB_INVALIDATE,
        SRQ_OP_CACHE_WB_KEEP,
        SRQ_OP_CACHE_INVALIDATE_DISCARD,
        SRQ_OP_TLB_ENTRY_INVALIDATE
    } srq_op_e;

    // Serialization classes
    typedef enum logic [1:0] {
        SRQ_SER_NONE,
        SRQ_SER_DISPATCH,
        SRQ_SER_FULL
    } srq_ser_e;

    localparam int          SRQ_OP_W            = 5;
    localparam int          SRQ_MSR_W           = 32;
    localparam int          SRQ_CNT_W           = 8;

    // Model registers whose writes do not serialize
    localparam logic [31:0] SRQ_MSR_SPECULATION = 32'h0000_0048;
    localparam logic [31:0] SRQ_MSR_PREDICTION  = 32'h0000_0049;
    localparam logic [31:0] SRQ_MSR_X2IC_BASE   = 32'h0000_0800;
    localparam logic [31:0] SRQ_MSR_X2IC_LAST   = 32'h0000_08FF;

    // Query leaves
    localparam logic [31:0] SRQ_LEAF_EXT_FEAT   = 32'h8000_0001;
    localparam logic [31:0] SRQ_LEAF_SIZE_ID    = 32'h8000_0008;
    localparam logic [31:0] SRQ_LEAF_CACHE_TOPO = 32'h8000_001D;
    localparam logic [31:0] SRQ_LEAF_PROC_TOPO  = 32'h8000_001E;
    localparam logic [31:0] SRQ_LEAF_FEAT21     = 32'h8000_0021;
    localparam int          SRQ_LOAD_FENCE_BIT  = 2;
    localparam int          SRQ_CACHE_TYPE_MSB  = 4;
    localparam int          SRQ_CACHE_LEVELS    = 4;
    localparam int          SRQ_EXT_TOPO_BIT    = 22;

endpackage

// ### srq_topo_rom.sv
`timescale 1ns/10ps

// Topology query answer table, one flop stage
module srq_topo_rom
    import srq_pkg::*;
#(
    parameter int          LEVELS     = SRQ_CACHE_LEVELS,
    parameter logic [31:0] CACHE_ACC0 = 32'h0000_0121,
    parameter logic [31:0] CACHE_ACC1 = 32'h0000_0122,
    parameter logic [31:0] CACHE_ACC2 = 32'h0000_0143,
    parameter logic [31:0] CACHE_ACC3 = 32'h0000_0163,
    parameter logic [31:0] CACHE_BASE = 32'h01C0_003F,
    parameter logic [31:0] CACHE_CNT  = 32'h0000_003F,
    parameter logic [31:0] CACHE_DATA = 32'h0000_0000
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Query
    input  wire logic        qValid,
    input  wire logic [31:0] qLeaf,
    input  wire logic [31:0] qSub,
    input  wire logic [31:0] icId,
    input  wire logic [7:0]  computeUnitId,
    input  wire logic [7:0]  coresPerUnit,
    input  wire logic [7:0]  nodeId,
    input  wire logic [2:0]  nodesPerPkg,
    input  wire logic        loadFenceSer,
    // Answer
    output logic             aValid,
    output logic [31:0]      aAcc,
    output logic [31:0]      aBase,
    output logic [31:0]      aCount,
    output logic [31:0]      aData
);

    logic [31:0] acc_nxt, base_nxt, cnt_nxt, dat_nxt;
    logic [31:0] acc_r, base_r, cnt_r, dat_r;
    logic        valid_r;
    logic [31:0] cacheAcc [LEVELS];

    // Per-level descriptor table
    assign cacheAcc[0] = CACHE_ACC0;
    assign cacheAcc[1] = CACHE_ACC1;
    assign cacheAcc[2] = CACHE_ACC2;
    assign cacheAcc[3] = CACHE_ACC3;

    // Leaf decode
    always_comb
    begin
        acc_nxt  = '0;
        base_nxt = '0;
        cnt_nxt  = '0;
        dat_nxt  = '0;
        case (qLeaf)
            SRQ_LEAF_EXT_FEAT:
            begin
                cnt_nxt[SRQ_EXT_TOPO_BIT] = 1'b1;
            end
            SRQ_LEAF_SIZE_ID:
            begin
                cnt_nxt = {24'h0, coresPerUnit - 8'h01};
            end
            SRQ_LEAF_CACHE_TOPO:
            begin
                // Out-of-range subleaf gives type zero: end of list
                if (qSub < 32'(LEVELS))
                begin
                    acc_nxt  = cacheAcc[qSub[1:0]];
                    base_nxt = CACHE_BASE;
                    cnt_nxt  = CACHE_CNT;
                    dat_nxt  = CACHE_DATA;
                end
            end
            SRQ_LEAF_PROC_TOPO:
            begin
                acc_nxt  = icId;
                // Count minus one: any count, even one or odd
                base_nxt = {16'h0, coresPerUnit - 8'h01, computeUnitId};
                cnt_nxt  = {21'h0, nodesPerPkg, nodeId};
            end
            SRQ_LEAF_FEAT21:
            begin
                acc_nxt[SRQ_LOAD_FENCE_BIT] = loadFenceSer;
            end
            default:
            begin
                acc_nxt = '0;
            end
        endcase
    end

    // Answer registers
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            valid_r <= 1'b0;
            acc_r   <= '0;
            base_r  <= '0;
            cnt_r   <= '0;
            dat_r   <= '0;
        end
        else
        begin
            valid_r <= qValid;
            acc_r   <= acc_nxt;
            base_r  <= base_nxt;
            cnt_r   <= cnt_nxt;
            dat_r   <= dat_nxt;
        end
    end

    assign aValid = valid_r;
    assign aAcc   = acc_r;
    assign aBase  = base_r;
    assign aCount = cnt_r;
    assign aData  = dat_r;

endmodule

// ### srq_serialize_ctrl.sv
`timescale 1ns/10ps

// What this block does
// - Full serializer: retire it and all older before fetching next.
// - Retired only after execute, register update, own stores, write buffers drained.
// - Identify query, interrupt return, resume, full fence are fully serializing.
// - Privileged moves, table loads, model write, cache ops, TLB invalidate serialize.
// - Model writes to speculation, prediction, extended controller registers do not.
// - Dispatch serializer: retire all older before next executes; fetch continues.
// - Load fence dispatch-serializing when the flag is set; flag shown bit 2.
// - Cache topology leaf by subleaf; accumulator bits 4:0 zero ends the list.
// - Processor topology leaf: controller id, compute unit, node id.
// - Topology reported in four leaves' result registers.
// - Single-core units and non-power-of-two counts described correctly.
// - Serializer is a barrier: memory operations never cross it.
module srq_serialize_ctrl
    import srq_pkg::*;
#(
    parameter int CNT_W = SRQ_CNT_W
)
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Decode side
    input  wire logic             decValid,
    input  wire logic [4:0]       decOp,
    input  wire logic [31:0]      decMsrIndex,
    input  wire logic             cfgLoadFenceSer,
    // Pipeline status
    input  wire logic [CNT_W-1:0] inFlightCount,
    input  wire logic             execDone,
    input  wire logic             regsUpdated,
    input  wire logic             ownMemDone,
    input  wire logic             writeBufEmpty,
    // Query operands
    input  wire logic [31:0]      queryLeaf,
    input  wire logic [31:0]      querySub,
    input  wire logic [31:0]      icId,
    input  wire logic [7:0]       computeUnitId,
    input  wire logic [7:0]       coresPerUnit,
    input  wire logic [7:0]       nodeId,
    input  wire logic [2:0]       nodesPerPkg,
    // Stall and barrier outputs
    output logic                  fetchHold,
    output logic                  dispatchHold,
    output logic                  memBarrier,
    output logic                  serRetire,
    // Query results
    output logic                  resValid,
    output logic [31:0]           resAcc,
    output logic [31:0]           resBase,
    output logic [31:0]           resCount,
    output logic [31:0]           resData
);

    // Sequencer states
    typedef enum logic [1:0] {
        SRQ_IDLE,
        SRQ_DRAIN,
        SRQ_COMPLETE
    } srq_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Classification

    srq_op_e  op;
    srq_ser_e serClass;
    logic     msrExempt;
    logic     lfSer_r;

    assign op = srq_op_e'(decOp);

    // Exempt model registers never stall the pipe
    assign msrExempt = (decMsrIndex == SRQ_MSR_SPECULATION)
                    || (decMsrIndex == SRQ_MSR_PREDICTION)
                    || ((decMsrIndex >= SRQ_MSR_X2IC_BASE) && (decMsrIndex <= SRQ_MSR_X2IC_LAST));

    // Serialization class of the decoded op; unknown codes never stall
    always_comb
    begin
        case (op)
            SRQ_OP_IDENTIFY_QUERY,
            SRQ_OP_INTERRUPT_RETURN,
            SRQ_OP_RESUME_SYS_MGMT,
            SRQ_OP_FULL_MEMORY_FENCE:        serClass = SRQ_SER_FULL;
            SRQ_OP_CONTROL_REG_MOVE,
            SRQ_OP_DEBUG_REG_MOVE,
            SRQ_OP_GDT_LOAD,
            SRQ_OP_IDT_LOAD,
            SRQ_OP_LDT_LOAD,
            SRQ_OP_TASK_REG_LOAD,
            SRQ_OP_CACHE_WB_INVALIDATE,
            SRQ_OP_CACHE_WB_KEEP,
            SRQ_OP_CACHE_INVALIDATE_DISCARD,
            SRQ_OP_TLB_ENTRY_INVALIDATE:     serClass = SRQ_SER_FULL;
            SRQ_OP_MODEL_REG_WRITE:          serClass = msrExempt ? SRQ_SER_NONE : SRQ_SER_FULL;
            SRQ_OP_LOAD_FENCE:               serClass = lfSer_r ? SRQ_SER_DISPATCH : SRQ_SER_NONE;
            default:                         serClass = SRQ_SER_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serialization sequencer

    srq_state_e state_r, state_nxt;
    logic       full_r, full_nxt;
    logic       fetchHold_r, fetchHold_nxt;
    logic       dispHold_r, dispHold_nxt;
    logic       barrier_r, barrier_nxt;
    logic       retire_r, retire_nxt;
    logic       retireReady;

    // All four completion conditions plus no older work left
    assign retireReady = (inFlightCount == '0) && execDone && regsUpdated
                      && ownMemDone && writeBufEmpty;

    // Next state; holds are levels, retire is a one-cycle pulse
    always_comb
    begin
        state_nxt     = state_r;
        full_nxt      = full_r;
        fetchHold_nxt = fetchHold_r;
        dispHold_nxt  = dispHold_r;
        barrier_nxt   = barrier_r;
        retire_nxt    = 1'b0;
        case (state_r)
            SRQ_IDLE:
            begin
                if (decValid && (serClass != SRQ_SER_NONE))
                begin
                    full_nxt      = (serClass == SRQ_SER_FULL);
                    fetchHold_nxt = (serClass == SRQ_SER_FULL);
                    dispHold_nxt  = 1'b1;
                    barrier_nxt   = 1'b1;
                    state_nxt     = SRQ_DRAIN;
                end
            end
            SRQ_DRAIN:
            begin
                // Holds stay up until the instruction truly retires
                fetchHold_nxt = full_r;
                if (retireReady)
                begin
                    retire_nxt = 1'b1;
                    state_nxt  = SRQ_COMPLETE;
                end
            end
            SRQ_COMPLETE:
            begin
                // One cycle of release; a new serializer starts from idle
                fetchHold_nxt = 1'b0;
                dispHold_nxt  = 1'b0;
                barrier_nxt   = 1'b0;
                full_nxt      = 1'b0;
                state_nxt     = SRQ_IDLE;
            end
            default:
            begin
                state_nxt     = SRQ_IDLE;
                fetchHold_nxt = 1'b0;
                dispHold_nxt  = 1'b0;
                barrier_nxt   = 1'b0;
                full_nxt      = 1'b0;
            end
        endcase
    end

    // State flops; load fence flag taken once so a class never shifts mid-decode
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_r     <= SRQ_IDLE;
            full_r      <= 1'b0;
            fetchHold_r <= 1'b0;
            dispHold_r  <= 1'b0;
            barrier_r   <= 1'b0;
            retire_r    <= 1'b0;
            lfSer_r     <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            full_r      <= full_nxt;
            fetchHold_r <= fetchHold_nxt;
            dispHold_r  <= dispHold_nxt;
            barrier_r   <= barrier_nxt;
            retire_r    <= retire_nxt;
            lfSer_r     <= cfgLoadFenceSer; // Same-domain config, registered once
        end
    end

    // Outputs straight from flops, no logic after them
    assign fetchHold    = fetchHold_r;
    assign dispatchHold = dispHold_r;
    assign memBarrier   = barrier_r;
    assign serRetire    = retire_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Topology query answers

    // Answers sit in their own flop stage, off the stall path
    srq_topo_rom u_topo
    (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .qValid        (decValid && (op == SRQ_OP_IDENTIFY_QUERY)),
        .qLeaf         (queryLeaf),
        .qSub          (querySub),
        .icId          (icId),
        .computeUnitId (computeUnitId),
        .coresPerUnit  (coresPerUnit),
        .nodeId        (nodeId),
        .nodesPerPkg   (nodesPerPkg),
        .loadFenceSer  (lfSer_r),
        .aValid        (resValid),
        .aAcc          (resAcc),
        .aBase         (resBase),
        .aCount        (resCount),
        .aData         (resData)
    );

endmodule

// ### srq_serialize_chk.sv
`timescale 1ns/10ps

// Port-level checker for the serialization controller
module srq_serialize_chk
    import srq_pkg::*;
#(
    parameter int CNT_W = SRQ_CNT_W
)
(
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             resetn,
    // Decode and status
    input wire logic             decValid,
    input wire logic [4:0]       decOp,
    input wire logic [31:0]      decMsrIndex,
    input wire logic             cfgLoadFenceSer,
    input wire logic [CNT_W-1:0] inFlightCount,
    input wire logic             execDone,
    input wire logic             regsUpdated,
    input wire logic             ownMemDone,
    input wire logic             writeBufEmpty,
    // Outputs under watch
    input wire logic             fetchHold,
    input wire logic             dispatchHold,
    input wire logic             memBarrier,
    input wire logic             serRetire,
    input wire logic             resValid
);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers; idle means no hold standing
    logic take;
    logic exempt;
    logic fullOp;
    logic allDone;
    assign take    = decValid && !dispatchHold;
    assign exempt  = decMsrIndex == SRQ_MSR_SPECULATION || decMsrIndex == SRQ_MSR_PREDICTION
                     || (decMsrIndex >= SRQ_MSR_X2IC_BASE && decMsrIndex <= SRQ_MSR_X2IC_LAST);
    assign fullOp  = decOp inside {[SRQ_OP_IDENTIFY_QUERY:SRQ_OP_FULL_MEMORY_FENCE],
                                   [SRQ_OP_CONTROL_REG_MOVE:SRQ_OP_TLB_ENTRY_INVALIDATE]}
                     && !(decOp == SRQ_OP_MODEL_REG_WRITE && exempt);
    assign allDone = execDone && regsUpdated && ownMemDone && writeBufEmpty && inFlightCount == '0;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    chk_full_hold_rise:
        assert property (take && fullOp |=> fetchHold && dispatchHold && memBarrier)
        else $error("full serializer did not raise all holds");
    chk_no_serialize:
        assert property (take && (decOp == SRQ_OP_PLAIN || (decOp == SRQ_OP_MODEL_REG_WRITE && exempt))
                         |=> !dispatchHold)
        else $error("non-serializing instruction raised a hold");
    chk_load_fence_disp:
        assert property (take && decOp == SRQ_OP_LOAD_FENCE && $past(resetn) && cfgLoadFenceSer
                         && $past(cfgLoadFenceSer) |=> dispatchHold && !fetchHold)
        else $error("configured load fence not dispatch serializing");
    chk_load_fence_plain:
        assert property (take && decOp == SRQ_OP_LOAD_FENCE && $past(resetn) && !cfgLoadFenceSer
                         && !$past(cfgLoadFenceSer) |=> !dispatchHold)
        else $error("unconfigured load fence held dispatch");
    chk_retire_cause:
        assert property ($rose(serRetire) |-> $past(allDone) && $past(dispatchHold))
        else $error("retire without completion");
    chk_retire_prompt:
        assert property (dispatchHold && !serRetire && allDone |=> serRetire)
        else $error("retire late after completion");
    chk_retire_pulse:
        assert property (serRetire |=> !serRetire && !fetchHold && !dispatchHold && !memBarrier)
        else $error("holds did not drop after retire");
    chk_hold_stays:
        assert property (dispatchHold && !serRetire |=> dispatchHold && $stable(fetchHold))
        else $error("hold dropped before retire");
    chk_barrier_match:
        assert property (memBarrier == dispatchHold && (!fetchHold || dispatchHold))
        else $error("barrier and holds disagree");
    chk_query_answer:
        assert property (decValid && decOp == SRQ_OP_IDENTIFY_QUERY |=> resValid)
        else $error("query not answered next cycle");

endmodule

// ### testbench.sv
`timescale 1ns/10ps

module testbench
    import srq_pkg::*;
();

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic        sys_clk         = 1'h0;
    logic        resetn          = 1'h0;
    logic        decValid        = 1'h0;
    logic [4:0]  decOp           = 5'h00;
    logic [31:0] decMsrIndex     = 32'h0000_0000;
    logic        cfgLoadFenceSer = 1'h0;
    logic [7:0]  inFlightCount   = 8'h00;
    logic        execDone        = 1'h1;
    logic        regsUpdated     = 1'h1;
    logic        ownMemDone      = 1'h1;
    logic        writeBufEmpty   = 1'h1;
    logic [31:0] queryLeaf       = 32'h0000_0000;
    logic [31:0] querySub        = 32'h0000_0000;
    logic [31:0] icId            = 32'h0000_0017;
    logic [7:0]  computeUnitId   = 8'h05;
    logic [7:0]  coresPerUnit    = 8'h01;
    logic [7:0]  nodeId          = 8'h02;
    logic [2:0]  nodesPerPkg     = 3'h3;
    logic        fetchHold;
    logic        dispatchHold;
    logic        memBarrier;
    logic        serRetire;
    logic        resValid;
    logic [31:0] resAcc;
    logic [31:0] resBase;
    logic [31:0] resCount;
    logic [31:0] resData;
    int          mismatches      = 0;
    int          checksDone      = 0;

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    srq_serialize_ctrl dut (.sys_clk, .resetn, .decValid, .decOp, .decMsrIndex, .cfgLoadFenceSer,
        .inFlightCount, .execDone, .regsUpdated, .ownMemDone, .writeBufEmpty, .queryLeaf, .querySub,
        .icId, .computeUnitId, .coresPerUnit, .nodeId, .nodesPerPkg, .fetchHold, .dispatchHold,
        .memBarrier, .serRetire, .resValid, .resAcc, .resBase, .resCount, .resData);

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Present one instruction; return just after the edge that takes it
    task automatic issue(input srq_op_e op, input logic [31:0] msr);
        @(posedge sys_clk);
        decValid    <= 1'h1;
        decOp       <= op;
        decMsrIndex <= msr;
        @(posedge sys_clk);
        decValid <= 1'h0;
        #1;
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    // Full walk with completion already satisfied
    task automatic walk(input srq_op_e op, input logic [31:0] msr, input logic full, input logic disp);
        issue(op, msr);
        check("fetchHold", 32'(fetchHold), 32'(full));
        check("dispatchHold", 32'(dispatchHold), 32'(disp));
        check("memBarrier", 32'(memBarrier), 32'(disp));
        step();
        check("serRetire", 32'(serRetire), 32'(disp));
        step();
        check("holdDrop", 32'(dispatchHold), 32'h0);
    endtask

    // Query answers come back one cycle after the take
    task automatic query(input logic [31:0] leaf, input logic [31:0] sub);
        @(posedge sys_clk);
        queryLeaf <= leaf;
        querySub  <= sub;
        issue(SRQ_OP_IDENTIFY_QUERY, 32'h0000_0000);
        check("resValid", 32'(resValid), 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic testFullOps();
        srq_op_e ops[15] = '{SRQ_OP_IDENTIFY_QUERY, SRQ_OP_INTERRUPT_RETURN, SRQ_OP_RESUME_SYS_MGMT,
            SRQ_OP_FULL_MEMORY_FENCE, SRQ_OP_CONTROL_REG_MOVE, SRQ_OP_DEBUG_REG_MOVE, SRQ_OP_GDT_LOAD,
            SRQ_OP_IDT_LOAD, SRQ_OP_LDT_LOAD, SRQ_OP_TASK_REG_LOAD, SRQ_OP_MODEL_REG_WRITE,
            SRQ_OP_CACHE_WB_INVALIDATE, SRQ_OP_CACHE_WB_KEEP, SRQ_OP_CACHE_INVALIDATE_DISCARD,
            SRQ_OP_TLB_ENTRY_INVALIDATE};
        foreach (ops[i])
            walk(ops[i], 32'h0000_0010, 1'h1, 1'h1);
        walk(SRQ_OP_PLAIN, 32'h0000_0000, 1'h0, 1'h0);
    endtask

    // Exempt model registers at both range edges, neighbours serialize
    task automatic testMsr();
        logic [31:0] idx[8] = '{32'h0000_0048, 32'h0000_0049, 32'h0000_0800, 32'h0000_08FF,
                                32'h0000_0047, 32'h0000_004A, 32'h0000_07FF, 32'h0000_0900};
        foreach (idx[i])
            walk(SRQ_OP_MODEL_REG_WRITE, idx[i], i >= 4, i >= 4);
    endtask

    // Each completion condition alone blocks retire; a request while busy is ignored
    task automatic testDrain();
        for (int i = 0; i < 5; i++)
        begin
            @(posedge sys_clk);
            {execDone, regsUpdated, ownMemDone, writeBufEmpty} <= ~(4'h1 << i);
            inFlightCount <= (i == 4) ? 8'h01 : 8'h00;
            issue(SRQ_OP_FULL_MEMORY_FENCE, 32'h0000_0000);
            issue(SRQ_OP_INTERRUPT_RETURN, 32'h0000_0000);
            step();
            check("blockedRetire", 32'(serRetire), 32'h0);
            check("blockedFetch", 32'(fetchHold), 32'h1);
            @(posedge sys_clk);
            {execDone, regsUpdated, ownMemDone, writeBufEmpty} <= 4'hF;
            inFlightCount <= 8'h00;
            step();
            check("lateRetire", 32'(serRetire), 32'h1);
            step();
            step();
            check("ignoredReq", 32'(dispatchHold), 32'h0);
        end
    endtask

    task automatic testLoadFence();
        @(posedge sys_clk);
        cfgLoadFenceSer <= 1'h1;
        walk(SRQ_OP_LOAD_FENCE, 32'h0000_0000, 1'h0, 1'h1);
        query(SRQ_LEAF_FEAT21, 32'h0000_0000);
        check("fenceFlag", 32'(resAcc[SRQ_LOAD_FENCE_BIT]), 32'h1);
        step();
        @(posedge sys_clk);
        cfgLoadFenceSer <= 1'h0;
        walk(SRQ_OP_LOAD_FENCE, 32'h0000_0000, 1'h0, 1'h0);
    endtask

    // Cache levels end with type zero; single and three-core units
    task automatic testTopology();
        logic [7:0] cores[2] = '{8'h01, 8'h03};
        for (int s = 0; s <= SRQ_CACHE_LEVELS; s++)
        begin
            query(SRQ_LEAF_CACHE_TOPO, 32'(s));
            check("cacheType", 32'(resAcc[4:0] != 5'h00), 32'(s < SRQ_CACHE_LEVELS));
            // Past the last level every result word reads zero
            if (s == SRQ_CACHE_LEVELS)
            begin
                check("endBase", resBase, 32'h0000_0000);
                check("endCount", resCount, 32'h0000_0000);
                check("endData", resData, 32'h0000_0000);
            end
            step();
        end
        foreach (cores[i])
        begin
            @(posedge sys_clk);
            coresPerUnit <= cores[i];
            query(SRQ_LEAF_PROC_TOPO, 32'h0000_0000);
            check("icId", resAcc, icId);
            check("unit", 32'(resBase[15:0]), 32'({coresPerUnit - 8'h01, computeUnitId}));
            check("node", 32'(resCount[10:0]), 32'({nodesPerPkg, nodeId}));
            step();
            query(SRQ_LEAF_SIZE_ID, 32'h0000_0000);
            check("coreCount", 32'(resCount[7:0]), 32'(coresPerUnit - 8'h01));
            step();
            query(SRQ_LEAF_EXT_FEAT, 32'h0000_0000);
            check("topoFlag", 32'(resCount[SRQ_EXT_TOPO_BIT]), 32'h1);
            step();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'h1;
        testFullOps();
        testMsr();
        testDrain();
        testLoadFence();
        testTopology();
        giveVerdict();
    end

    // Run needs about 220 cycles; 5000 leaves ample margin
    initial
    begin
        #(50 * 5000);
        mismatches++;
        giveVerdict();
    end

endmodule

bind srq_serialize_ctrl srq_serialize_chk #(.CNT_W(CNT_W)) uChk (.sys_clk, .resetn, .decValid, .decOp,
    .decMsrIndex, .cfgLoadFenceSer, .inFlightCount, .execDone, .regsUpdated, .ownMemDone, .writeBufEmpty,
    .fetchHold, .dispatchHold, .memBarrier, .serRetire, .resValid);
